// >>> src/i2cs_regs.vh
/*
 * Constants of the I2C slave with bus time-out: register byte offsets,
 * field positions, reset values and protocol counts.
 * Assumes it is included by bare name from the design files under src/.
 */
// Functional notes
// - start is sda fall while scl high; busy set
// - shift 7-bit address msb first, compare own
// - address match sets flag, raises interrupt
// - eighth bit captured into read/write flag
// - matched address acknowledged low on ninth bit
// - one interrupt: match, byte done, time-out
// - scl held low until data write or read
// - direction follows software transmit select bit
// - data bytes eight bits, msb first
// - receiver acknowledges low after eight bits
// - receiver drives ack-to-send bit on ninth clock
// - transmitter samples master ack; nack releases sda
// - counter starts at match, scl fall clears
// - elapsed period before scl fall signals time-out
// - overflow stops counter, clears enable, sets flag
// - time-out resets bus logic and status register
// - counter ticks sub clock over 32, (sel+1)
// - time-out control all read/write, reset zero
// - slave active only mode 110 and enabled
// - byte done sets done flag, interrupt; zero meanwhile
// - stop clears the bus busy flag
`ifndef I2CS_REGS_VH
`define I2CS_REGS_VH

// ============================================================
// register byte offsets
`define I2CS_OFS_DATA       5'h00
`define I2CS_OFS_OWNADDR    5'h04
`define I2CS_OFS_MODECTL    5'h08
`define I2CS_OFS_STATUS     5'h0C
`define I2CS_OFS_TOCTL      5'h10

// ============================================================
// mode control fields
`define I2CS_MODE_HI        7
`define I2CS_MODE_LO        5
`define I2CS_MODE_I2C       3'h6
`define I2CS_MODE_RST       3'h7
`define I2CS_EN_BIT         1
`define I2CS_DEB_HI         3
`define I2CS_DEB_LO         2

// ============================================================
// bus status fields and reset value
`define I2CS_ST_DONE        7
`define I2CS_ST_MATCH       6
`define I2CS_ST_BUSY        5
`define I2CS_ST_TXSEL       4
`define I2CS_ST_ACKSEND     3
`define I2CS_ST_RW          2
`define I2CS_ST_WAKE        1
`define I2CS_ST_RXACK       0
`define I2CS_ST_RST         8'h81

// ============================================================
// time-out control fields
`define I2CS_TO_EN          7
`define I2CS_TO_FLAG        6
`define I2CS_TO_SEL_HI      5
`define I2CS_TO_RST         8'h00

// ============================================================
// counts
`define I2CS_BITS_BYTE      4'h8
`define I2CS_SUBDIV_LAST    5'h1F

`endif

// >>> src/i2cs_slave.v
/*
 * I2C slave-only serial interface with bus time-out watchdog, registers
 * reached over Avalon-MM with waitrequest (32-bit data, byte addresses),
 * and the two-flop synchroniser that every asynchronous input passes.
 * Assumes open-drain scl/sda resolved outside from the enables, and a
 * free-running sub clock sampled as a plain asynchronous input.
 */
`timescale 1ns/1ns
`include "i2cs_regs.vh"

module i2cs_slave (
	// system
	input  wire        clk,
	input  wire        rst_n,
	// avalon-mm slave
	input  wire [4:0]  address,
	input  wire        read,
	input  wire        write,
	input  wire [31:0] writedata,
	input  wire [3:0]  byteenable,
	output reg  [31:0] readdata,
	output reg         waitrequest,
	// i2c pins, open drain
	input  wire        sclIn,
	output reg         sclOut,
	output reg         sclOe,
	input  wire        sdaIn,
	output reg         sdaOut,
	output reg         sdaOe,
	// sub clock and interrupt
	input  wire        subClk,
	output reg         irq
);

	// ============================================================
	// states
	localparam [3:0] ST_IDLE  = 4'h0;
	localparam [3:0] ST_ADDR  = 4'h1;
	localparam [3:0] ST_AACK  = 4'h2;
	localparam [3:0] ST_HOLD  = 4'h3;
	localparam [3:0] ST_RX    = 4'h4;
	localparam [3:0] ST_RACK  = 4'h5;
	localparam [3:0] ST_TX    = 4'h6;
	localparam [3:0] ST_TACK  = 4'h7;
	localparam [3:0] ST_WSTOP = 4'h8;

	// ============================================================
	// input synchronisers
	wire      scl;
	wire      sda;
	wire      subSync;
	reg       sclPrev_q;
	reg       sdaPrev_q;
	reg       subPrev_q;

	// lines idle high, so a reset value of one avoids a false edge
	i2cs_sync #(
		.RST_VAL (1'b1)
	) u_i2cs_sync_scl (
		.clk    (clk),
		.rst_n  (rst_n),
		.raw    (sclIn),
		.synced (scl)
	);
	i2cs_sync #(
		.RST_VAL (1'b1)
	) u_i2cs_sync_sda (
		.clk    (clk),
		.rst_n  (rst_n),
		.raw    (sdaIn),
		.synced (sda)
	);
	i2cs_sync #(
		.RST_VAL (1'b0)
	) u_i2cs_sync_sub (
		.clk    (clk),
		.rst_n  (rst_n),
		.raw    (subClk),
		.synced (subSync)
	);

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sclPrev_q <= 1'h1;
			sdaPrev_q <= 1'h1;
			subPrev_q <= 1'h0;
		end else begin
			sclPrev_q <= scl;
			sdaPrev_q <= sda;
			subPrev_q <= subSync;
		end
	end

	wire sclRise  = scl & ~sclPrev_q;
	wire sclFall  = ~scl & sclPrev_q;
	wire startDet = scl & sclPrev_q & sdaPrev_q & ~sda;
	wire stopDet  = scl & sclPrev_q & ~sdaPrev_q & sda;
	wire subRise  = subSync & ~subPrev_q;

	// ============================================================
	// registers and state
	reg [7:0] dataReg_q;
	reg [7:0] ownAddr_q;
	reg [7:0] modeCtl_q;
	reg [7:0] status_q;
	reg [7:0] toCtl_q;
	reg [3:0] state_q;
	reg [3:0] bitCnt_q;
	reg [7:0] shift_q;
	reg [4:0] subDiv_q;
	reg [5:0] toCnt_q;
	reg       toRun_q;

	wire active = (modeCtl_q[`I2CS_MODE_HI:`I2CS_MODE_LO] == `I2CS_MODE_I2C)
		& modeCtl_q[`I2CS_EN_BIT];
	wire wrEn  = write & ~waitrequest & byteenable[0];
	wire rdEn  = read & ~waitrequest;
	wire wrData = wrEn & (address == `I2CS_OFS_DATA);
	wire rdData = rdEn & (address == `I2CS_OFS_DATA);
	wire wrSt  = wrEn & (address == `I2CS_OFS_STATUS);
	wire wrTo  = wrEn & (address == `I2CS_OFS_TOCTL);
	wire byteDone = (bitCnt_q == `I2CS_BITS_BYTE);
	wire match = (shift_q[7:1] == ownAddr_q[7:1]);
	wire toTick = toRun_q & subRise & (subDiv_q == `I2CS_SUBDIV_LAST);
	// (sel+1) ticks of sub/32 elapse before overflow
	wire toOvf = toTick & (toCnt_q == toCtl_q[`I2CS_TO_SEL_HI:0]);

	// ============================================================
	// avalon handshake: one wait cycle, then answer
	reg [7:0] rdMux;
	always @* begin
		case (address)
			`I2CS_OFS_DATA:    rdMux = dataReg_q;
			`I2CS_OFS_OWNADDR: rdMux = ownAddr_q;
			`I2CS_OFS_MODECTL: rdMux = {modeCtl_q[7:5], 1'b0, modeCtl_q[3:0]};
			`I2CS_OFS_STATUS:  rdMux = status_q;
			`I2CS_OFS_TOCTL:   rdMux = toCtl_q;
			default:           rdMux = 8'h00;
		endcase
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			waitrequest <= 1'b1;
			readdata    <= 32'h0;
		end else begin
			waitrequest <= ~((read | write) & waitrequest);
			if (read & waitrequest)
				readdata <= {24'h0, rdMux};
		end
	end

	// ============================================================
	// sub clock divider; the time-out counter is kept in the protocol engine
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			subDiv_q <= 5'h0;
		end else if (subRise) begin
			subDiv_q <= subDiv_q + 5'h1;
		end
	end

	// ============================================================
	// protocol engine and register file
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dataReg_q <= 8'h00;
			ownAddr_q <= 8'h00;
			modeCtl_q <= {`I2CS_MODE_RST, 5'h00};
			status_q  <= `I2CS_ST_RST;
			toCtl_q   <= `I2CS_TO_RST;
			state_q   <= ST_IDLE;
			bitCnt_q  <= 4'h0;
			shift_q   <= 8'h00;
			toCnt_q   <= 6'h0;
			toRun_q   <= 1'b0;
			sclOut    <= 1'b0;
			sclOe     <= 1'b0;
			sdaOut    <= 1'b0;
			sdaOe     <= 1'b0;
			irq       <= 1'b0;
		end else begin
			irq <= 1'b0;
			// software writes
			if (wrEn && address == `I2CS_OFS_OWNADDR)
				ownAddr_q <= writedata[7:0];
			if (wrEn && address == `I2CS_OFS_MODECTL)
				modeCtl_q <= writedata[7:0];
			if (wrData)
				dataReg_q <= writedata[7:0];
			if (wrSt) begin
				status_q[`I2CS_ST_TXSEL]   <= writedata[`I2CS_ST_TXSEL];
				status_q[`I2CS_ST_ACKSEND] <= writedata[`I2CS_ST_ACKSEND];
				status_q[`I2CS_ST_WAKE]    <= writedata[`I2CS_ST_WAKE];
			end
			if (wrTo)
				toCtl_q <= writedata[7:0];
			// time-out counter
			if (sclFall) begin
				toCnt_q <= 6'h0;
			end else if (toTick) begin
				toCnt_q <= toCnt_q + 6'h1;
			end

			if (!active) begin
				// disabled: flags idle, pins released
				status_q[`I2CS_ST_DONE]  <= 1'b1;
				status_q[`I2CS_ST_MATCH] <= 1'b0;
				status_q[`I2CS_ST_BUSY]  <= 1'b0;
				status_q[`I2CS_ST_RW]    <= 1'b0;
				status_q[`I2CS_ST_RXACK] <= 1'b1;
				state_q <= ST_IDLE;
				toRun_q <= 1'b0;
				sclOe   <= 1'b0;
				sdaOe   <= 1'b0;
			end else if (toOvf) begin
				// bus logic back to idle; data, address, mode untouched
				toRun_q <= 1'b0;
				toCtl_q[`I2CS_TO_EN]   <= 1'b0;
				toCtl_q[`I2CS_TO_FLAG] <= 1'b1;
				irq      <= 1'b1;
				status_q <= `I2CS_ST_RST;
				state_q  <= ST_IDLE;
				sclOe    <= 1'b0;
				sdaOe    <= 1'b0;
			end else if (stopDet) begin
				status_q[`I2CS_ST_BUSY] <= 1'b0;
				toRun_q <= 1'b0;
				state_q <= ST_IDLE;
				sclOe   <= 1'b0;
				sdaOe   <= 1'b0;
			end else if (startDet) begin
				// a repeated start restarts the address phase too
				status_q[`I2CS_ST_BUSY]  <= 1'b1;
				status_q[`I2CS_ST_MATCH] <= 1'b0;
				status_q[`I2CS_ST_DONE]  <= 1'b0;
				state_q  <= ST_ADDR;
				bitCnt_q <= 4'h0;
				sclOe    <= 1'b0;
				sdaOe    <= 1'b0;
			end else begin
				case (state_q)
				ST_ADDR: begin
					if (sclRise) begin
						shift_q  <= {shift_q[6:0], sda};
						bitCnt_q <= bitCnt_q + 4'h1;
					end else if (sclFall && byteDone) begin
						if (match) begin
							status_q[`I2CS_ST_MATCH] <= 1'b1;
							status_q[`I2CS_ST_RW]    <= shift_q[0];
							irq     <= 1'b1;
							sdaOe   <= 1'b1;
							toRun_q <= toCtl_q[`I2CS_TO_EN];
							state_q <= ST_AACK;
						end else begin
							state_q <= ST_WSTOP;
						end
					end
				end
				ST_AACK: begin
					if (sclFall) begin
						sdaOe   <= 1'b0;
						sclOe   <= 1'b1;
						status_q[`I2CS_ST_DONE] <= 1'b1;
						state_q <= ST_HOLD;
					end
				end
				ST_HOLD: begin
					// stretch until software touches the data register
					if (wrData && status_q[`I2CS_ST_TXSEL]) begin
						// first bit goes out now, scl is let go in the next cycle
						shift_q  <= writedata[7:0];
						sdaOe    <= ~writedata[7];
						bitCnt_q <= 4'h0;
						status_q[`I2CS_ST_DONE] <= 1'b0;
						state_q  <= ST_TX;
					end else if (rdData && !status_q[`I2CS_ST_TXSEL]) begin
						bitCnt_q <= 4'h0;
						sclOe    <= 1'b0;
						status_q[`I2CS_ST_DONE] <= 1'b0;
						state_q  <= ST_RX;
					end
				end
				ST_RX: begin
					if (sclRise) begin
						shift_q  <= {shift_q[6:0], sda};
						bitCnt_q <= bitCnt_q + 4'h1;
					end else if (sclFall && byteDone) begin
						dataReg_q <= shift_q;
						status_q[`I2CS_ST_DONE] <= 1'b1;
						irq     <= 1'b1;
						sdaOe   <= ~status_q[`I2CS_ST_ACKSEND];
						state_q <= ST_RACK;
					end
				end
				ST_RACK: begin
					if (sclFall) begin
						sdaOe   <= 1'b0;
						sclOe   <= 1'b1;
						state_q <= ST_HOLD;
					end
				end
				ST_TX: begin
					// releasing scl a cycle after sda gives the first bit its setup time
					sclOe <= 1'b0;
					if (sclRise) begin
						bitCnt_q <= bitCnt_q + 4'h1;
					end else if (sclFall) begin
						if (byteDone) begin
							sdaOe   <= 1'b0;
							state_q <= ST_TACK;
						end else begin
							shift_q <= {shift_q[6:0], 1'b0};
							sdaOe   <= ~shift_q[6];
						end
					end
				end
				ST_TACK: begin
					if (sclRise) begin
						status_q[`I2CS_ST_RXACK] <= sda;
					end else if (sclFall) begin
						status_q[`I2CS_ST_DONE] <= 1'b1;
						irq <= 1'b1;
						if (!status_q[`I2CS_ST_RXACK]) begin
							sclOe   <= 1'b1;
							state_q <= ST_HOLD;
						end else begin
							state_q <= ST_WSTOP;
						end
					end
				end
				ST_IDLE, ST_WSTOP: begin
					// idle or waiting for stop: lines released
					sdaOe <= 1'b0;
					sclOe <= 1'b0;
				end
				default: begin
					// unused codes fall back to idle with the lines released
					state_q <= ST_IDLE;
					sdaOe   <= 1'b0;
					sclOe   <= 1'b0;
				end
				endcase
			end
			// flag set by overflow wins over a software clear
			if (wrTo && !(active && toOvf))
				toCtl_q[`I2CS_TO_FLAG] <= writedata[`I2CS_TO_FLAG];
		end
	end

endmodule // i2cs_slave

// ============================================================
// two-flop synchroniser for one asynchronous input
module i2cs_sync #(
	parameter [0:0] RST_VAL = 1'b0
) (
	// system
	input  wire clk,
	input  wire rst_n,
	// asynchronous level and its synchronised copy
	input  wire raw,
	output wire synced
);

	// only the second stage is read, so a metastable first stage stays inside
	reg [1:0] stage_q;

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stage_q <= {2{RST_VAL}};
		end else begin
			stage_q <= {stage_q[0], raw};
		end
	end

	assign synced = stage_q[1];

endmodule // i2cs_sync

// >>> dv/i2cs_checker.sv
/* Port checker for the I2C slave: bus answer timing, interrupt pulse, pins.
   Assumes it is bound onto i2cs_slave. */
`timescale 1ns/1ns
module i2cs_checker (
	// system
	input wire logic        clk,
	input wire logic        rst_n,
	// register bus
	input wire logic        read,
	input wire logic        write,
	input wire logic [31:0] readdata,
	input wire logic        waitrequest,
	// pins and interrupt
	input wire logic        sclIn,
	input wire logic        sclOut,
	input wire logic        sclOe,
	input wire logic        sdaOut,
	input wire logic        sdaOe,
	input wire logic        irq
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	// ==========
	// register bus
	AST_ANSWER: assert property ($rose(read || write) |=> !waitrequest)
		else $error("bus answer late");
	AST_ONE_CYCLE: assert property (!waitrequest |=> waitrequest)
		else $error("answer longer than one cycle");
	AST_IDLE_WAIT: assert property (!(read || write) |-> waitrequest)
		else $error("answer without request");
	AST_HIGH_ZERO: assert property (read && !waitrequest |-> readdata[31:8] == 24'h0)
		else $error("upper read bits set");
	// ==========
	// pins and interrupt
	AST_IRQ_PULSE: assert property (irq |=> !irq)
		else $error("interrupt longer than one cycle");
	AST_SDA_SCL_LOW: assert property ($changed(sdaOe) |-> !sclIn)
		else $error("sda moved while scl high");
	AST_STRETCH_LOW: assert property ($rose(sclOe) |-> !sclIn)
		else $error("stretch began with scl high");
	AST_OPEN_DRAIN: assert property (!sclOut && !sdaOut)
		else $error("pin driven high");
	cover property ($rose(sclOe));
	cover property (irq);
	cover property ($fell(sdaOe));
endmodule // i2cs_checker

// >>> dv/i2cs_master_model.sv
/* I2C master model facing the slave.
   Assumes pull-ups: a line is high unless some party pulls it low. */
`timescale 1ns/1ns
module i2cs_master_model #(parameter int Q = 25) (
	// system
	input  wire logic clk,
	// resolved lines and pulls
	input  wire logic scl,
	input  wire logic sda,
	output logic      sclLow,
	output logic      sdaLow
);
	initial begin
		sclLow = 1'b0;
		sdaLow = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic start();
		sdaLow <= 1'b1;
		tick(Q);
		sclLow <= 1'b1;
		tick(Q);
	endtask
	// waits out any stretch by the slave
	task automatic bitx(input logic b, output logic r);
		sdaLow <= !b;
		tick(Q);
		sclLow <= 1'b0;
		do tick(1); while (scl !== 1'b1);
		tick(Q);
		r = sda;
		sclLow <= 1'b1;
		tick(Q);
	endtask
	task automatic xfer(input logic [7:0] tx, input logic ackOut,
		output logic [7:0] rx, output logic ackIn);
		for (int i = 7; i >= 0; i--) bitx(tx[i], rx[i]);
		bitx(ackOut, ackIn);
	endtask
	task automatic stop();
		sdaLow <= 1'b1;
		tick(Q);
		sclLow <= 1'b0;
		do tick(1); while (scl !== 1'b1);
		tick(Q);
		sdaLow <= 1'b0;
		tick(Q);
	endtask
endmodule // i2cs_master_model

// >>> dv/testbench.sv
/* Self-checking bench of the I2C slave with bus time-out.
   Assumes the slave, the master model and the checker. */
`timescale 1ns/1ns
module testbench;
	logic        clk, rst_n = 0, read = 0, write = 0, mScl, mSda, subClk = 0;
	logic        waitrequest, irq, sclOut, sclOe, sdaOut, sdaOe;
	logic [4:0]  address = 0;
	logic [31:0] writedata = 0, readdata, q;
	logic [2:0]  subDiv = 0;
	int          error_cnt = 0, checks = 0, cyc = 0, irqCnt = 0;
	wire         scl = !(sclOe | mScl);
	wire         sda = !(sdaOe | mSda);
	i2cs_slave u_i2cs_slave (.clk, .rst_n, .address, .read, .write, .writedata,
		.byteenable(4'h1), .readdata, .waitrequest, .sclIn(scl), .sclOut, .sclOe,
		.sdaIn(sda), .sdaOut, .sdaOe, .subClk, .irq);
	i2cs_master_model u_m (.clk, .scl, .sda, .sclLow(mScl), .sdaLow(mSda));
	initial begin
		clk = 0;
		forever #2 clk = ~clk;
	end
	// sub clock at one eighth of clk; also watchdog and interrupt count
	always @(posedge clk) begin
		subDiv <= subDiv + 1;
		subClk <= subDiv[2];
		cyc <= cyc + 1;
		if (irq === 1'b1) irqCnt <= irqCnt + 1;
		if (cyc == 60000) begin
			error_cnt++;
			complete_run();
		end
	end
	task automatic complete_run();
		if (error_cnt == 0 && checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] seen, exp);
		checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] %s exp %h seen %h", n, exp, seen);
		end
	endtask
	task automatic busOp(input logic wr, input logic [4:0] a, input logic [31:0] d,
		output logic [31:0] r);
		@(posedge clk);
		read <= !wr;
		write <= wr;
		address <= a;
		writedata <= d;
		do @(posedge clk); while (waitrequest !== 1'b0);
		r = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask
	task automatic rd(input logic [4:0] a);
		busOp(1'b0, a, 32'h0, q);
	endtask
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		logic [31:0] unused;
		busOp(1'b1, a, d, unused);
	endtask
	task automatic regScn();
		logic [7:0] rv[5] = '{8'h00, 8'h00, 8'hE0, 8'h81, 8'h00};
		for (int i = 0; i < 5; i++) begin
			rd(5'(i * 4));
			chk("reset value", q, {24'h0, rv[i]});
		end
		wr(5'h10, 32'hFF);
		rd(5'h10);
		chk("toctl", q, 32'hFF);
		wr(5'h14, 32'hFF);
		rd(5'h14);
		chk("unmapped", q, 32'h0);
		wr(5'h10, 32'h0);
	endtask
	task automatic rxScn();
		logic [7:0] rx;
		logic ak;
		int n0;
		n0 = irqCnt;
		wr(5'h04, 32'h50);
		wr(5'h08, 32'hC2);
		u_m.start();
		rd(5'h0C);
		chk("busy", q[5], 1);
		u_m.xfer({7'h28, 1'b0}, 1'b1, rx, ak);
		chk("addr ack", ak, 0);
		chk("irq", irqCnt > n0, 1);
		chk("stretch", sclOe, 1);
		rd(5'h0C);
		chk("match", q[6], 1);
		chk("rw", q[2], 0);
		wr(5'h0C, 32'h0);
		rd(5'h00);
		u_m.xfer(8'hA5, 1'b1, rx, ak);
		chk("rx ack", ak, 0);
		rd(5'h0C);
		chk("done", q[7], 1);
		rd(5'h00);
		chk("rx data", q, 32'hA5);
		wr(5'h0C, 32'h08);
		u_m.xfer(8'h3C, 1'b1, rx, ak);
		chk("rx nack", ak, 1);
		rd(5'h00);
		chk("rx data", q, 32'h3C);
		u_m.stop();
		rd(5'h0C);
		chk("free", q[5], 0);
	endtask
	task automatic txScn();
		logic [7:0] rx;
		logic ak;
		u_m.start();
		u_m.xfer({7'h28, 1'b1}, 1'b1, rx, ak);
		chk("addr ack", ak, 0);
		rd(5'h0C);
		chk("rw", q[2], 1);
		wr(5'h0C, 32'h10);
		wr(5'h00, 32'hC3);
		u_m.xfer(8'hFF, 1'b0, rx, ak);
		chk("tx data", rx, 8'hC3);
		rd(5'h0C);
		chk("rx ack", q[0], 0);
		wr(5'h00, 32'h5A);
		u_m.xfer(8'hFF, 1'b1, rx, ak);
		chk("tx data", rx, 8'h5A);
		rd(5'h0C);
		chk("rx nack", q[0], 1);
		chk("sda free", sdaOe, 0);
		u_m.stop();
	endtask
	task automatic nackScn();
		logic [7:0] rx;
		logic ak;
		logic [7:0] md[3] = '{8'hC0, 8'hE2, 8'hC2};
		logic [6:0] ad[3] = '{7'h28, 7'h28, 7'h29};
		for (int i = 0; i < 3; i++) begin
			wr(5'h08, {24'h0, md[i]});
			u_m.start();
			u_m.xfer({ad[i], 1'b0}, 1'b1, rx, ak);
			chk("no ack", ak, 1);
			u_m.stop();
		end
		wr(5'h08, 32'hC2);
	endtask
	task automatic toScn();
		logic [7:0] rx;
		logic ak;
		int n;
		wr(5'h0C, 32'h02);
		wr(5'h10, 32'h81);
		u_m.start();
		u_m.xfer({7'h28, 1'b0}, 1'b1, rx, ak);
		rd(5'h00);
		u_m.xfer(8'h11, 1'b1, rx, ak);
		rd(5'h10);
		chk("no early timeout", q, 32'h81);
		n = 0;
		while (irq !== 1'b1 && n < 2000) begin
			@(posedge clk);
			n++;
		end
		chk("timeout delay", n >= 230 && n <= 520, 1);
		rd(5'h10);
		chk("toctl", q, 32'h41);
		rd(5'h0C);
		chk("status", q, 32'h81);
		rd(5'h04);
		chk("own", q, 32'h50);
		rd(5'h08);
		chk("mode", q, 32'hC2);
		rd(5'h00);
		chk("data", q, 32'h11);
		chk("scl free", sclOe, 0);
		wr(5'h10, 32'h0);
		rd(5'h10);
		chk("flag clear", q, 32'h0);
		u_m.stop();
	endtask
	initial begin
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		regScn();
		rxScn();
		txScn();
		nackScn();
		toScn();
		complete_run();
	end
endmodule // testbench
bind i2cs_slave i2cs_checker u_i2cs_checker (.clk, .rst_n, .read, .write, .readdata,
	.waitrequest, .sclIn, .sclOut, .sclOe, .sdaOut, .sdaOe, .irq);
